/* File: logic/pel_pkg.sv */
// Package with register map, field layout and carrier types of the peripheral enable lock block.
// ==========================================================================
// Overview of operation
// - Enable bits 31:7 read zero, ignore writes.
// - Bit 6 enables video port two, reset 0.
// - Bit 5 enables video port one, reset 0.
// - Bit 3 enables two-wire controller, reset 0.
// - Bit 2 enables serial port one, resets 1.
// - Bit 1 enables serial port zero, reset 1.
// - Bit 0 selects audio or upper video pins.
// - Lower video pins ignore audio select bit.
// - Exact key write unlocks enable register.
// - Lock read: bit0 status, resets locked.
// - Locked writes leave enable register unchanged.
// - Enable reads ignore lock status.
// - Any enable write relocks the register.
// - Registers sit on configuration bus block.
package pel_pkg;

  // ==========================================================================
  // Address map
  // Base of the 4K configuration block.
  localparam logic [31:0] PEL_BLOCK_BASE = 32'h01b3_f000;
  // Mask that keeps the block number above the 4K window.
  localparam logic [31:0] PEL_BLOCK_MASK = 32'hffff_f000;
  // Full byte address of the peripheral_enable register.
  localparam logic [31:0] PEL_ENABLE_ADDR = 32'h01b3_f000;
  // Full byte address of the enable_lock_key register.
  localparam logic [31:0] PEL_LOCK_ADDR = 32'h01b3_f018;

  // ==========================================================================
  // Field layout and reset values
  localparam int PEL_AUDIO_SEL_BIT = 0;
  localparam int PEL_BSER0_BIT = 1;
  localparam int PEL_BSER1_BIT = 2;
  localparam int PEL_TWOWIRE_BIT = 3;
  localparam int PEL_VP1_BIT = 5;
  localparam int PEL_VP2_BIT = 6;
  localparam int PEL_LOCK_STATUS_BIT = 0;
  // Writable bits of the enable register, bits 4 and 31:7 stay zero.
  localparam logic [31:0] PEL_ENABLE_WMASK = 32'h0000_006f;
  // Reset value: both buffered serial bits set, everything else clear.
  localparam logic [31:0] PEL_ENABLE_RESET = 32'h0000_0006;
  // Key that opens the enable register for one write.
  localparam logic [31:0] PEL_UNLOCK_KEY = 32'h10c0_010c;
  // Reset value of the lock status, locked.
  localparam logic PEL_LOCK_RESET = 1'b1;
  // Least wait after enabling, in CPU cycles, kept for software reference.
  localparam int PEL_POST_ENABLE_WAIT = 128;

  // ==========================================================================
  // Carrier types
  // One access on the configuration bus.
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pel_bus_req_t;

  // Answer to an access, one cycle after it is taken.
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } pel_bus_rsp_t;

  // Gates and pin selects that follow from the enable register.
  typedef struct packed {
    logic vp2_en;
    logic vp1_en;
    logic twowire_en;
    logic bser1_en;
    logic bser0_en;
    logic audio_en;
    logic vp1_upper_en;
    logic vp1_lower_en;
  } pel_ctrl_t;

endpackage

/* File: logic/pel_lock.sv */
// Lock status keeper that opens the enable register for a single write.
`timescale 1ns/1ps
module pel_lock (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic key_wr_i,
  input wire logic [31:0] key_data_i,
  input wire logic enable_wr_i,
  output logic locked_o
);
  import pel_pkg::*;

  // ==========================================================================
  // Lock state
  logic locked_q;
  logic locked_d;

  // Next lock value; an enable write relocks even if a key arrives with it.
  always_comb begin
    locked_d = locked_q;
    if (key_wr_i && (key_data_i == PEL_UNLOCK_KEY)) begin
      locked_d = 1'b0;
    end
    if (enable_wr_i) begin
      locked_d = 1'b1;
    end
  end

  // Register the lock status, locked after reset.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_q <= PEL_LOCK_RESET;
    end else begin
      locked_q <= locked_d;
    end
  end

  assign locked_o = locked_q;

  // ==========================================================================
  // Checks
  a_key_unlocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    key_wr_i && key_data_i == PEL_UNLOCK_KEY && !enable_wr_i |=> !locked_q)
    else $error("Key write did not unlock");
  a_bad_key_keeps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    key_wr_i && key_data_i != PEL_UNLOCK_KEY && !enable_wr_i |=> locked_q == $past(locked_q))
    else $error("Wrong key changed lock status");
  a_write_relocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_wr_i |=> locked_q)
    else $error("Enable write did not relock");
  c_unlock: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(locked_q));

endmodule

/* File: logic/pel_top.sv */
// Peripheral enable register with key lock on the configuration bus.
`timescale 1ns/1ps
module pel_top (
  // Clock and asynchronous active-low reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Configuration bus request and its registered answer.
  input pel_pkg::pel_bus_req_t bus_req_i,
  output pel_pkg::pel_bus_rsp_t bus_rsp_o,
  // Peripheral gates and pin selects.
  output pel_pkg::pel_ctrl_t ctrl_o
);
  import pel_pkg::*;

  // ==========================================================================
  // Address decode
  // Decode results are plain combinational views of the request in the
  // current cycle; nothing here is registered, so a request is taken on the
  // very edge at which it is presented.
  // Address lies inside the 4K configuration block.
  logic in_block;
  // Address is exactly the peripheral_enable word.
  logic hit_enable;
  // Address is exactly the enable_lock_key word.
  logic hit_lock;
  // Write strobe for the peripheral_enable register.
  logic enable_wr;
  // Write strobe for the enable_lock_key register.
  logic key_wr;
  // Current lock status from the lock keeper, high while locked.
  logic locked;

  // Full-word compares are used on purpose: there are no byte enables, so a
  // sub-word address inside a register is treated as an unmapped word.
  // configuration block decode
  always_comb begin
    in_block = (bus_req_i.addr & PEL_BLOCK_MASK) == PEL_BLOCK_BASE;
    hit_enable = bus_req_i.addr == PEL_ENABLE_ADDR;
    hit_lock = bus_req_i.addr == PEL_LOCK_ADDR;
    enable_wr = bus_req_i.req && bus_req_i.wr && hit_enable;
    key_wr = bus_req_i.req && bus_req_i.wr && hit_lock;
  end

  // The lock keeper sees the same cycle's writes.
  // It is a module of its own so that the key compare and its checks stay in one small place.
  pel_lock u_lock (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .key_wr_i(key_wr),
    .key_data_i(bus_req_i.wdata),
    .enable_wr_i(enable_wr),
    .locked_o(locked)
  );

  // ==========================================================================
  // Enable register
  // Stored peripheral_enable value, reserved bits always zero.
  logic [31:0] enable_q;
  // Value that the next edge will store.
  logic [31:0] enable_d;

  // Next enable value; the lock is sampled before this write relocks it.
  always_comb begin
    enable_d = enable_q;
    if (enable_wr && !locked) begin
      // reserved bits stay zero
      // Bit 2 stays writable so that software can clear it after reset.
      enable_d = bus_req_i.wdata & PEL_ENABLE_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_q <= PEL_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ==========================================================================
  // Read answer
  // Registered answer driven onto the bus.
  pel_bus_rsp_t rsp_q;
  // Answer that the next edge will register.
  pel_bus_rsp_t rsp_d;

  // Every access gets an ack next cycle; addresses outside the two registers
  // read zero, and those outside the block also flag an error.
  // Empty words in the block answer zero, so software probing it never stalls.
  always_comb begin
    rsp_d = '0;
    rsp_d.ack = bus_req_i.req;
    rsp_d.err = bus_req_i.req && !in_block;
    if (bus_req_i.req && !bus_req_i.wr) begin
      if (hit_enable) begin
        rsp_d.rdata = enable_q;
      end else if (hit_lock) begin
        // lock status readback
        // The other 31 bits keep the zero from the default above.
        rsp_d.rdata[PEL_LOCK_STATUS_BIT] = locked;
      end
    end
  end

  // Register the answer; it stands for exactly one cycle after the taking edge,
  // which keeps the bus free of any stall logic.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ==========================================================================
  // Peripheral gates and pin selects
  // Registered gates and pin selects.
  pel_ctrl_t ctrl_q;
  // Gates that the next edge will register.
  pel_ctrl_t ctrl_d;

  // Gates follow the register; software keeps the 128-cycle wait itself,
  // so there is no delay here and no guard against early access.
  // Taking the gates from the next value keeps them in step with the register;
  // gates taken from enable_q would lag it by one cycle.
  always_comb begin
    ctrl_d.vp2_en = enable_d[PEL_VP2_BIT];
    ctrl_d.vp1_en = enable_d[PEL_VP1_BIT];
    ctrl_d.twowire_en = enable_d[PEL_TWOWIRE_BIT];
    ctrl_d.bser1_en = enable_d[PEL_BSER1_BIT];
    ctrl_d.bser0_en = enable_d[PEL_BSER0_BIT];
    ctrl_d.audio_en = enable_d[PEL_AUDIO_SEL_BIT];
    ctrl_d.vp1_upper_en = !enable_d[PEL_AUDIO_SEL_BIT];
    ctrl_d.vp1_lower_en = enable_d[PEL_VP1_BIT] && !enable_d[PEL_BSER1_BIT];
  end

  // Register the gates. The reset values repeat those of the enable register,
  // so that the gates agree with the register from the first cycle on and no
  // peripheral sees a short power-up glitch at reset release.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= '0;
      ctrl_q.bser1_en <= PEL_ENABLE_RESET[PEL_BSER1_BIT];
      ctrl_q.bser0_en <= PEL_ENABLE_RESET[PEL_BSER0_BIT];
      ctrl_q.vp1_upper_en <= !PEL_ENABLE_RESET[PEL_AUDIO_SEL_BIT];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Both outputs come straight from flip-flops.
  assign bus_rsp_o = rsp_q;
  assign ctrl_o = ctrl_q;

  // ==========================================================================
  // Checks
  // All checks sleep while reset is low; the reset checks below look at the
  // first edge after release instead.
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_q[31:7] == 25'h0 && !enable_q[4])
    else $error("Reserved enable bits not zero");
  a_locked_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_wr && locked |=> $stable(enable_q))
    else $error("Locked write changed enable register");
  a_unlocked_takes: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_wr && !locked |=> enable_q == ($past(bus_req_i.wdata) & PEL_ENABLE_WMASK))
    else $error("Unlocked write not stored");
  a_enable_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_req_i.req && !bus_req_i.wr && hit_enable |=> bus_rsp_o.ack && bus_rsp_o.rdata == $past(enable_q))
    else $error("Enable read wrong");
  a_lock_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_req_i.req && !bus_req_i.wr && hit_lock |=> bus_rsp_o.rdata == {31'h0, $past(locked)})
    else $error("Lock read wrong");
  a_lower_pins: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl_o.vp1_lower_en == (enable_q[PEL_VP1_BIT] && !enable_q[PEL_BSER1_BIT]))
    else $error("Lower pin select wrong");
  a_gates_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl_o.vp2_en == enable_q[PEL_VP2_BIT] && ctrl_o.audio_en == enable_q[PEL_AUDIO_SEL_BIT]
    && ctrl_o.vp1_upper_en != enable_q[PEL_AUDIO_SEL_BIT])
    else $error("Gates do not follow register");
  // Bus answer: one ack per taken request, errors only outside the block.
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_rsp_o.ack == $past(bus_req_i.req))
    else $error("Ack does not follow request");
  a_err_outside: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_req_i.req |=> bus_rsp_o.err == !$past(in_block))
    else $error("Error flag wrong");
  a_write_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus_req_i.req && bus_req_i.wr |=> bus_rsp_o.rdata == 32'h0000_0000)
    else $error("Write answer carries data");
  // Reset values, seen at the first edge after reset is released.
  a_reset_enable: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> enable_q == PEL_ENABLE_RESET)
    else $error("Enable register reset value wrong");
  a_reset_locked: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> locked)
    else $error("Lock status not locked after reset");
  a_reset_gates: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> ctrl_o.bser1_en && ctrl_o.bser0_en && ctrl_o.vp1_upper_en
    && !ctrl_o.vp2_en && !ctrl_o.vp1_en && !ctrl_o.twowire_en && !ctrl_o.audio_en && !ctrl_o.vp1_lower_en)
    else $error("Gates wrong after reset");
  // Gates not watched above, and their stability between effective writes.
  a_port_gates: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl_o.vp1_en == enable_q[PEL_VP1_BIT] && ctrl_o.twowire_en == enable_q[PEL_TWOWIRE_BIT])
    else $error("Port gates do not follow register");
  a_serial_gates: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl_o.bser1_en == enable_q[PEL_BSER1_BIT] && ctrl_o.bser0_en == enable_q[PEL_BSER0_BIT])
    else $error("Serial gates do not follow register");
  a_gates_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(enable_wr && !locked) |=> $stable(ctrl_o))
    else $error("Gates changed without a write");
  // Scenarios worth seeing in a run.
  c_vp1_on: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(ctrl_o.vp1_en));
  c_locked_write: cover property (@(posedge clk_i) disable iff (!nrst_i) enable_wr && locked);
  c_bser1_off: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(ctrl_o.bser1_en));
  c_bad_key: cover property (@(posedge clk_i) disable iff (!nrst_i) key_wr && bus_req_i.wdata != PEL_UNLOCK_KEY);

endmodule

/* File: verification/pel_cpu_model.sv */
// CPU-side model that issues word accesses on the configuration bus.
`timescale 1ns/1ps
module pel_cpu_model (
  input wire logic clk_i,
  output pel_pkg::pel_bus_req_t bus_req_o,
  input pel_pkg::pel_bus_rsp_t bus_rsp_i
);
  import pel_pkg::*;
  // ====================
  // Bus access
  // The bus starts idle so that nothing is taken during reset.
  initial begin
    bus_req_o = '0;
  end
  // One access: request on a falling edge, answer taken in the cycle after the taking edge.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic ack);
    @(negedge clk_i);
    bus_req_o = {1'b1, wr, addr, wdata};
    @(negedge clk_i);
    // Released lines carry inverted values, so a stale address never passes for a live one.
    bus_req_o = {1'b0, ~wr, ~addr, ~wdata};
    ack = bus_rsp_i.ack;
    err = bus_rsp_i.err;
    rdata = bus_rsp_i.rdata;
  endtask
  // ====================
  // Software enable flow
  // key first, then all wanted enables in a single write.
  task automatic enable_all(input logic [31:0] value, output logic [31:0] readback);
    logic [31:0] rd;
    logic e;
    logic a;
    xfer(1'b1, PEL_LOCK_ADDR, PEL_UNLOCK_KEY, rd, e, a);
    xfer(1'b1, PEL_ENABLE_ADDR, value, rd, e, a);
    // read back so the write has landed before the wait starts.
    xfer(1'b0, PEL_ENABLE_ADDR, '0, readback, e, a);
    // no peripheral traffic at all until the settling time has passed.
    repeat (PEL_POST_ENABLE_WAIT) @(negedge clk_i);
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the peripheral enable lock block.
`timescale 1ns/1ps
module tb;
  import pel_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  pel_bus_req_t bus_req;
  pel_bus_rsp_t bus_rsp;
  pel_ctrl_t ctrl;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 26412;
  // History of accepted enable values; the last entry is the live register.
  logic [31:0] hist_q[$];
  logic [31:0] exp_en;
  logic [31:0] rd;
  logic [31:0] val;
  logic err;
  logic ack;
  always #12.5 clk_i = ~clk_i;
  pel_top pel_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req), .bus_rsp_o(bus_rsp), .ctrl_o(ctrl));
  pel_cpu_model pel_cpu_model_i (.clk_i(clk_i), .bus_req_o(bus_req), .bus_rsp_i(bus_rsp));
  // ====================
  // Reference model and checks
  // Gates and pin selects expected from an enable value, in carrier field order.
  function automatic logic [7:0] ctrl_exp(input logic [31:0] e);
    return {e[6], e[5], e[3], e[2], e[1], e[0], ~e[0], e[5] & ~e[2]};
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One access, then answer and gates compared with the reference state.
  task automatic acc(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     input logic [31:0] exp_rd, input logic exp_err);
    pel_cpu_model_i.xfer(wr, addr, wd, rd, err, ack);
    check("ack", 32'h1, {31'h0, ack});
    check("err", {31'h0, exp_err}, {31'h0, err});
    check("rdata", exp_rd, rd);
    check("ctrl", {24'h0, ctrl_exp(exp_en)}, {24'h0, ctrl});
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs about 1110 cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  // ====================
  // Main sequence
  initial begin
    hist_q.push_back(PEL_ENABLE_RESET);
    exp_en = hist_q[$];
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    acc(1'b0, PEL_ENABLE_ADDR, '0, 32'h6, 1'b0);
    acc(1'b0, PEL_LOCK_ADDR, '0, 32'h1, 1'b0);
    // A locked write is dropped and a near-miss key keeps the lock.
    acc(1'b1, PEL_ENABLE_ADDR, 32'hffff_ffff, '0, 1'b0);
    acc(1'b1, PEL_LOCK_ADDR, PEL_UNLOCK_KEY ^ 32'h1, '0, 1'b0);
    acc(1'b0, PEL_LOCK_ADDR, '0, 32'h1, 1'b0);
    // The key opens the register for exactly one write.
    acc(1'b1, PEL_LOCK_ADDR, PEL_UNLOCK_KEY, '0, 1'b0);
    acc(1'b0, PEL_LOCK_ADDR, '0, 32'h0, 1'b0);
    acc(1'b0, PEL_ENABLE_ADDR, '0, 32'h6, 1'b0);
    hist_q.push_back(32'h6f);
    exp_en = hist_q[$];
    acc(1'b1, PEL_ENABLE_ADDR, 32'hffff_ffff, '0, 1'b0);
    acc(1'b0, PEL_LOCK_ADDR, '0, 32'h1, 1'b0);
    acc(1'b1, PEL_ENABLE_ADDR, 32'h0, '0, 1'b0);
    acc(1'b0, PEL_ENABLE_ADDR, '0, 32'h6f, 1'b0);
    // An empty word inside the block reads zero; outside the block it errs.
    acc(1'b0, PEL_BLOCK_BASE + 32'h4, '0, '0, 1'b0);
    acc(1'b0, 32'h01b4_0000, '0, '0, 1'b1);
    // Random enable sets through the full software flow.
    for (int i = 0; i < 8; i++) begin
      // bit 2 kept clear and the audio select held at one.
      val = ($random(seed) & ~32'h4) | 32'h1;
      hist_q.push_back(val & 32'h6f);
      exp_en = hist_q[$];
      pel_cpu_model_i.enable_all(val, rd);
      check("readback", exp_en, rd);
      check("ctrl", {24'h0, ctrl_exp(exp_en)}, {24'h0, ctrl});
    end
    final_report();
  end
endmodule
